// File: logic/dsf_device.sv
// Special-function command decoder, control register and channel monitor select.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module dsf_device #(
    parameter int          RESET_CYCLES = dsf_pkg::SOFT_RESET_CYC,
    parameter logic        REF_LEVEL_DEFAULT = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    dsf_link_if.dev          link,
    input  wire logic        powerdown_req,
    input  wire logic        powerup_req,
    input  wire logic        overtemp_in,
    input  wire logic        output_update_strobe,
    output logic             powerdown_output_mode_bit,
    output logic             ref_level_select_bit,
    output logic             amp_boost_bit,
    output logic             ref_source_bit,
    output logic             probe_enable_bit,
    output logic             overtemp_guard_bit,
    output logic [3:0]       toggle_group_enables,
    output logic [31:0]      ab_select,
    output logic             amps_off,
    output logic             dac_clear,
    output logic [5:0]       probe_select,
    output logic             probe_output_oe
);
    localparam logic [11:0] CTRL_DEF = dsf_pkg::CTRL_RESET |
                                       (12'(REF_LEVEL_DEFAULT) << dsf_pkg::POS_REF_LEVEL);

    logic [11:0] ctrl_r;
    logic [5:0]  mon_r;
    logic [12:0] rst_cnt_r;
    logic        pd_r;
    logic        thermal_r;
    logic        ot_s1_r;
    logic        ot_s2_r;
    logic        upd_s1_r;
    logic        upd_s2_r;
    logic        upd_d_r;
    logic        rd_valid_r;
    logic [11:0] rd_data_r;
    logic        special;
    logic        soft_rst;
    logic        wr_ok;
    logic        upd_pulse;

    assign special   = link.cmd_valid && link.target_select == dsf_pkg::SEL_SPECIAL;
    assign soft_rst  = special && link.function_address_field == dsf_pkg::FN_SOFT_RESET
                       && !pd_r && rst_cnt_r == '0;
    assign wr_ok     = special && !link.read_not_write && !pd_r && rst_cnt_r == '0;
    assign upd_pulse = upd_s2_r && !upd_d_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ot_s1_r  <= 1'b0;
            ot_s2_r  <= 1'b0;
            upd_s1_r <= 1'b0;
            upd_s2_r <= 1'b0;
            upd_d_r  <= 1'b0;
        end else begin
            ot_s1_r  <= overtemp_in;
            ot_s2_r  <= ot_s1_r;
            upd_s1_r <= output_update_strobe;
            upd_s2_r <= upd_s1_r;
            upd_d_r  <= upd_s2_r;
        end
    end

    // Busy counter; the reset effect lands on the command edge, well inside the limit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_r <= '0;
        end else if (soft_rst) begin
            rst_cnt_r <= 13'(RESET_CYCLES - 1);
        end else if (rst_cnt_r != '0) begin
            rst_cnt_r <= rst_cnt_r - 13'd1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_DEF;
        end else if (soft_rst) begin
            ctrl_r <= CTRL_DEF;
        end else if (wr_ok && link.function_address_field == dsf_pkg::FN_CONTROL) begin
            ctrl_r <= link.command_payload_field;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_r <= dsf_pkg::MON_OFF;
        end else if (soft_rst) begin
            mon_r <= dsf_pkg::MON_OFF;
        end else if (wr_ok && link.function_address_field == dsf_pkg::FN_MONITOR) begin
            mon_r <= link.command_payload_field[dsf_pkg::POS_MON_ADDR +: 6];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_r <= 1'b0;
        end else if (powerdown_req) begin
            pd_r <= 1'b1;
        end else if (powerup_req) begin
            pd_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_r <= 1'b0;
        end else if (ctrl_r[dsf_pkg::POS_OT_GUARD] && ot_s2_r) begin
            thermal_r <= 1'b1;
        end else if (powerup_req && !ot_s2_r) begin
            thermal_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_r <= 1'b0;
            rd_data_r  <= '0;
        end else begin
            rd_valid_r <= special && link.read_not_write
                          && link.function_address_field == dsf_pkg::FN_CONTROL;
            if (special && link.read_not_write
                && link.function_address_field == dsf_pkg::FN_CONTROL) begin
                rd_data_r <= ctrl_r;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < dsf_pkg::NUM_CHAN; g++) begin : g_ab
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ab_select[g] <= 1'b0;
                end else if (soft_rst || !ctrl_r[g / 8]) begin
                    ab_select[g] <= 1'b0;
                end else if (upd_pulse && rst_cnt_r == '0) begin
                    ab_select[g] <= ~ab_select[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerdown_output_mode_bit <= CTRL_DEF[dsf_pkg::POS_PD_MODE];
            ref_level_select_bit      <= REF_LEVEL_DEFAULT;
            amp_boost_bit             <= 1'b0;
            ref_source_bit            <= 1'b0;
            probe_enable_bit          <= 1'b0;
            overtemp_guard_bit        <= 1'b0;
            toggle_group_enables      <= '0;
            amps_off                  <= 1'b0;
            dac_clear                 <= 1'b0;
            probe_select              <= dsf_pkg::MON_OFF;
            probe_output_oe           <= 1'b0;
        end else begin
            powerdown_output_mode_bit <= ctrl_r[dsf_pkg::POS_PD_MODE];
            ref_level_select_bit      <= ctrl_r[dsf_pkg::POS_REF_LEVEL];
            amp_boost_bit             <= ctrl_r[dsf_pkg::POS_BOOST];
            ref_source_bit            <= ctrl_r[dsf_pkg::POS_REF_SRC];
            probe_enable_bit          <= ctrl_r[dsf_pkg::POS_PROBE_EN];
            overtemp_guard_bit        <= ctrl_r[dsf_pkg::POS_OT_GUARD];
            toggle_group_enables      <= ctrl_r[3:0];
            amps_off                  <= pd_r || thermal_r;
            dac_clear                 <= soft_rst;
            probe_select              <= mon_r;
            probe_output_oe           <= ctrl_r[dsf_pkg::POS_PROBE_EN]
                                         && (mon_r < 6'(dsf_pkg::NUM_CHAN)
                                         || (mon_r >= dsf_pkg::MON_AUX_FIRST
                                         && mon_r <= dsf_pkg::MON_AUX_LAST));
        end
    end

    assign link.busy         = rst_cnt_r != '0;
    assign link.rd_valid     = rd_valid_r;
    assign link.rd_data      = rd_data_r;
    assign link.powered_down = pd_r;
endmodule

// File: logic/dsf_pkg.sv
// Shared constants for the special-function command link.
package dsf_pkg;
    localparam int          FUNC_W         = 5;
    localparam int          DATA_W         = 12;
    localparam int          CHAN_ADDR_W    = 6;
    localparam int          NUM_CHAN       = 32;
    localparam int          NUM_GROUPS     = 4;
    localparam int          NUM_AUX        = 4;
    localparam logic [1:0]  SEL_SPECIAL    = 2'h0;
    localparam logic [4:0]  FN_NOP         = 5'h00;
    localparam logic [4:0]  FN_MONITOR     = 5'h0a;
    localparam logic [4:0]  FN_CONTROL     = 5'h0c;
    localparam logic [4:0]  FN_SOFT_RESET  = 5'h0f;
    localparam int          POS_PD_MODE    = 11;
    localparam int          POS_REF_LEVEL  = 10;
    localparam int          POS_BOOST      = 9;
    localparam int          POS_REF_SRC    = 8;
    localparam int          POS_PROBE_EN   = 7;
    localparam int          POS_OT_GUARD   = 6;
    localparam int          POS_MON_ADDR   = 6;
    localparam logic [11:0] CTRL_RESET     = 12'h800;
    localparam logic [11:0] GAIN_RESET     = 12'hffe;
    localparam logic [11:0] OFFSET_RESET   = 12'h800;
    localparam logic [5:0]  MON_OFF        = 6'h3f;
    localparam logic [5:0]  MON_AUX_FIRST  = 6'h22;
    localparam logic [5:0]  MON_AUX_LAST   = 6'h25;
    localparam int          CLK_MHZ        = 40;
    localparam int          SOFT_RESET_US  = 135;
    localparam int          SOFT_RESET_CYC = SOFT_RESET_US * CLK_MHZ;
    localparam logic [7:0]  HOST_WR_CTRL   = 8'h01;
    localparam logic [7:0]  HOST_RD_CTRL   = 8'h02;
    localparam logic [7:0]  HOST_MON_SEL   = 8'h03;
    localparam logic [7:0]  HOST_SOFT_RST  = 8'h04;
    localparam logic [7:0]  HOST_NOP       = 8'h05;
    localparam logic [7:0]  HOST_STATUS    = 8'h06;
    localparam logic [7:0]  HOST_READBACK  = 8'h07;
endpackage

// File: logic/dsf_link_if.sv
// Command link between the host controller and the special-function logic.
`timescale 1ns/1ps
interface dsf_link_if;
    logic        cmd_valid;
    logic [1:0]  target_select;
    logic [4:0]  function_address_field;
    logic        read_not_write;
    logic [11:0] command_payload_field;
    logic        busy;
    logic        rd_valid;
    logic [11:0] rd_data;
    logic        powered_down;
    modport host (output cmd_valid, target_select, function_address_field, read_not_write,
                  command_payload_field, input busy, rd_valid, rd_data, powered_down);
    modport dev (input cmd_valid, target_select, function_address_field, read_not_write,
                 command_payload_field, output busy, rd_valid, rd_data, powered_down);
endinterface

// File: logic/dsf_host.sv
// Host end: turns software register accesses into special-function commands.
`timescale 1ns/1ps
module dsf_host (
    input  wire logic        clk,
    input  wire logic        rst_n,
    dsf_link_if.host         link,
    input  wire logic [7:0]  addr,
    input  wire logic [11:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [11:0]      rdata,
    output logic             refused
);
    logic        cmd_valid_r;
    logic [4:0]  func_r;
    logic        rnw_r;
    logic [11:0] payload_r;
    logic [11:0] readback_r;
    logic        bad_rst;
    logic        busy_seen;

    // Soft reset is held back while the device is powered down.
    assign bad_rst = wr && addr == dsf_pkg::HOST_SOFT_RST && link.powered_down;

    // A soft reset still on the link counts as busy, so a write right behind it is refused.
    assign busy_seen = link.busy || (cmd_valid_r && func_r == dsf_pkg::FN_SOFT_RESET);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid_r <= 1'b0;
            func_r      <= dsf_pkg::FN_NOP;
            rnw_r       <= 1'b0;
            payload_r   <= '0;
        end else begin
            cmd_valid_r <= 1'b0;
            if (wr && !busy_seen && !bad_rst) begin
                unique case (addr)
                    dsf_pkg::HOST_WR_CTRL: begin
                        cmd_valid_r <= 1'b1;
                        func_r      <= dsf_pkg::FN_CONTROL;
                        rnw_r       <= 1'b0;
                        payload_r   <= wdata;
                    end
                    dsf_pkg::HOST_RD_CTRL: begin
                        cmd_valid_r <= 1'b1;
                        func_r      <= dsf_pkg::FN_CONTROL;
                        rnw_r       <= 1'b1;
                        payload_r   <= '0;
                    end
                    dsf_pkg::HOST_MON_SEL: begin
                        cmd_valid_r <= 1'b1;
                        func_r      <= dsf_pkg::FN_MONITOR;
                        rnw_r       <= 1'b0;
                        payload_r   <= {wdata[5:0], 6'h00};
                    end
                    dsf_pkg::HOST_SOFT_RST: begin
                        cmd_valid_r <= 1'b1;
                        func_r      <= dsf_pkg::FN_SOFT_RESET;
                        rnw_r       <= 1'b0;
                        payload_r   <= '0;
                    end
                    dsf_pkg::HOST_NOP: begin
                        cmd_valid_r <= 1'b1;
                        func_r      <= dsf_pkg::FN_NOP;
                        rnw_r       <= 1'b0;
                        payload_r   <= '0;
                    end
                    default: begin
                        cmd_valid_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refused <= 1'b0;
        end else if (wr) begin
            refused <= bad_rst || busy_seen;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readback_r <= '0;
        end else if (link.rd_valid) begin
            readback_r <= link.rd_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd && addr == dsf_pkg::HOST_STATUS) begin
            rdata <= {9'h000, refused, link.powered_down, link.busy};
        end else if (rd && addr == dsf_pkg::HOST_READBACK) begin
            rdata <= readback_r;
        end else begin
            rdata <= '0;
        end
    end

    assign link.cmd_valid              = cmd_valid_r;
    assign link.target_select          = dsf_pkg::SEL_SPECIAL;
    assign link.function_address_field = func_r;
    assign link.read_not_write         = rnw_r;
    assign link.command_payload_field  = payload_r;
endmodule

// File: testbench/dsf_link_monitor.sv
// Concurrent checks on the command link between host and device ends.
`timescale 1ns/1ps
module dsf_link_monitor #(
    parameter int          RESET_CYCLES = 8,
    parameter logic [11:0] CTRL_DEFAULT = 12'hc00
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cmd_valid,
    input wire logic [1:0]  target_select,
    input wire logic [4:0]  function_address_field,
    input wire logic        read_not_write,
    input wire logic [11:0] command_payload_field,
    input wire logic        busy,
    input wire logic        rd_valid,
    input wire logic [11:0] rd_data,
    input wire logic        powered_down
);
    logic        is_ctrl;
    logic        rd_cmd;
    logic        rst_cmd;
    logic [15:0] busy_cnt_r;
    logic [11:0] ctrl_r;
    assign is_ctrl = cmd_valid && target_select == 2'h0 && function_address_field == 5'h0c;
    assign rd_cmd  = is_ctrl && read_not_write;
    assign rst_cmd = cmd_valid && target_select == 2'h0 && function_address_field == 5'h0f;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) busy_cnt_r <= 16'h0;
        else busy_cnt_r <= busy ? busy_cnt_r + 16'h1 : 16'h0;
    end
    // Shadow of the control register, written only when the device may accept it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ctrl_r <= CTRL_DEFAULT;
        else if (rst_cmd) ctrl_r <= CTRL_DEFAULT;
        else if (is_ctrl && !read_not_write && !busy && !powered_down)
            ctrl_r <= command_payload_field;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    read_answer_a: assert property (rd_cmd |=> rd_valid)
        else $error("read not answered");
    read_cause_a: assert property (rd_valid |-> $past(rd_cmd))
        else $error("stray read data");
    read_value_a: assert property (rd_valid |-> rd_data == ctrl_r)
        else $error("bad read data");
    reset_busy_a: assert property (rst_cmd |=> busy)
        else $error("no busy after reset");
    busy_cause_a: assert property ($rose(busy) |-> $past(rst_cmd))
        else $error("stray busy");
    // The busy count is loaded with one less than the limit, so busy stands one cycle short of it.
    busy_len_a: assert property ($fell(busy) |-> busy_cnt_r == 16'(RESET_CYCLES - 1))
        else $error("busy len");
    no_reset_pd_a: assert property (rst_cmd |-> !powered_down)
        else $error("reset in powerdown");
    special_only_a: assert property (cmd_valid |-> target_select == 2'h0)
        else $error("bad select");
    nop_quiet_a: assert property (cmd_valid && function_address_field == 5'h00
        |=> !rd_valid && !$rose(busy)) else $error("idle code acted");
    no_write_busy_a: assert property (busy |-> !(cmd_valid && !read_not_write))
        else $error("write sent while busy");
endmodule

// File: testbench/tb_dac_special_function_regs.sv
// Self-checking bench joining host and device ends over the command link.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_dac_special_function_regs;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, pd_req = 0, pu_req = 0, ot_in = 0, upd = 0;
    logic [7:0]  addr = 8'h0;
    logic [11:0] wdata = 12'h0, rdata, v;
    logic        refused, pd_mode, ref_lvl, boost, ref_src, mon_en, guard, amps_off, dac_clr, poe;
    logic [3:0]  tg;
    logic [31:0] ab;
    logic [5:0]  psel;
    int          n_fail = 0, total_checks = 0, cycles = 0;
    always #12.5 clk = ~clk;
    dsf_link_if dsf_link_if_inst ();
    dsf_host dsf_host_inst (.clk(clk), .rst_n(rst_n), .link(dsf_link_if_inst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .refused(refused));
    dsf_device #(.RESET_CYCLES(8)) dsf_device_inst (.clk(clk), .rst_n(rst_n),
        .link(dsf_link_if_inst), .powerdown_req(pd_req), .powerup_req(pu_req),
        .overtemp_in(ot_in), .output_update_strobe(upd), .powerdown_output_mode_bit(pd_mode),
        .ref_level_select_bit(ref_lvl), .amp_boost_bit(boost), .ref_source_bit(ref_src),
        .probe_enable_bit(mon_en), .overtemp_guard_bit(guard), .toggle_group_enables(tg),
        .ab_select(ab), .amps_off(amps_off), .dac_clear(dac_clr), .probe_select(psel),
        .probe_output_oe(poe));
    dsf_link_monitor #(.RESET_CYCLES(8), .CTRL_DEFAULT(12'hc00)) dsf_link_monitor_inst (
        .clk(clk), .rst_n(rst_n), .cmd_valid(dsf_link_if_inst.cmd_valid),
        .target_select(dsf_link_if_inst.target_select),
        .function_address_field(dsf_link_if_inst.function_address_field),
        .read_not_write(dsf_link_if_inst.read_not_write),
        .command_payload_field(dsf_link_if_inst.command_payload_field),
        .busy(dsf_link_if_inst.busy), .rd_valid(dsf_link_if_inst.rd_valid),
        .rd_data(dsf_link_if_inst.rd_data), .powered_down(dsf_link_if_inst.powered_down));
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bwr(logic [7:0] a, logic [11:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic brd(logic [7:0] a);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rd_ctrl();
        bwr(8'h02, 12'h0);
        tick(3);
        brd(8'h07);
    endtask
    task automatic t_defaults();
        rd_ctrl();
        `CHK("ctrl", 12'hc00, v)
        `CHK("bits", 6'b110000, {pd_mode, ref_lvl, boost, ref_src, mon_en, guard})
        `CHK("oe", 1'b0, poe)
        bwr(8'h05, 12'hfff);
        rd_ctrl();
        `CHK("nop", 12'hc00, v)
        $display("defaults done");
    endtask
    task automatic t_ctrl();
        logic [11:0] vals [5] = '{12'h000, 12'hfff, 12'h5a5, 12'ha5a, 12'h830};
        foreach (vals[i]) begin
            bwr(8'h01, vals[i]);
            rd_ctrl();
            `CHK("ctrl", vals[i], v)
            v = {2'h0, pd_mode, ref_lvl, boost, ref_src, mon_en, guard, tg};
            `CHK("flds", {2'h0, vals[i][11:6], vals[i][3:0]}, v)
        end
        $display("control done");
    endtask
    task automatic t_monitor();
        logic [5:0] al [10] = '{6'h00, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h25, 6'h26, 6'h3d,
                                6'h3e, 6'h3f};
        logic e;
        bwr(8'h01, 12'h000);
        bwr(8'h03, 12'h005);
        tick(4);
        `CHK("oe off", 1'b0, poe)
        bwr(8'h01, 12'h080);
        foreach (al[i]) begin
            bwr(8'h03, {6'h0, al[i]});
            tick(4);
            e = al[i] < 32 || (al[i] >= 34 && al[i] <= 37);
            `CHK("oe", e, poe)
            if (e) `CHK("psel", al[i], psel)
        end
        bwr(8'h03, 12'h005);
        tick(4);
        `CHK("oe on", 1'b1, poe)
        `CHK("psel 5", 6'h05, psel)
        bwr(8'h01, 12'h000);
        tick(4);
        `CHK("oe dis", 1'b0, poe)
        $display("monitor done");
    endtask
    task automatic strobe();
        @(posedge clk);
        upd <= 1'b1;
        tick(2);
        upd <= 1'b0;
        tick(6);
    endtask
    task automatic t_toggle();
        bwr(8'h01, 12'h005);
        tick(3);
        `CHK("ab0", 32'h0, ab)
        strobe();
        `CHK("ab1", 32'h00ff00ff, ab)
        strobe();
        `CHK("ab2", 32'h0, ab)
        strobe();
        bwr(8'h01, 12'h001);
        tick(4);
        `CHK("ab3", 32'h000000ff, ab)
        $display("toggle done");
    endtask
    task automatic t_soft_reset();
        int n = 0;
        bwr(8'h01, 12'h3ff);
        tick(3);
        `CHK("pre", 1'b1, boost)
        bwr(8'h04, 12'h0);
        repeat (4) begin
            @(posedge clk);
            #1 if (dac_clr === 1'b1) n++;
        end
        `CHK("clear", 1, n)
        bwr(8'h01, 12'h0f0);
        brd(8'h06);
        `CHK("refused", 1'b1, v[2])
        for (int i = 0; i < 100 && dsf_link_if_inst.busy !== 1'b0; i++) @(posedge clk);
        `CHK("busy", 1'b0, dsf_link_if_inst.busy)
        rd_ctrl();
        `CHK("ctrl", 12'hc00, v)
        `CHK("ab", 32'h0, ab)
        $display("soft reset done");
    endtask
    task automatic t_power();
        @(posedge clk);
        pd_req <= 1'b1;
        @(posedge clk);
        pd_req <= 1'b0;
        brd(8'h06);
        `CHK("pd", 1'b1, v[1])
        bwr(8'h01, 12'h00f);
        rd_ctrl();
        `CHK("ctrl", 12'hc00, v)
        bwr(8'h04, 12'h0);
        brd(8'h06);
        `CHK("rst ref", 1'b1, v[2])
        `CHK("refused", 1'b1, refused)
        @(posedge clk);
        pu_req <= 1'b1;
        @(posedge clk);
        pu_req <= 1'b0;
        bwr(8'h01, 12'h040);
        @(posedge clk);
        ot_in <= 1'b1;
        tick(6);
        `CHK("hot", 1'b1, amps_off)
        pu_req <= 1'b1;
        @(posedge clk);
        pu_req <= 1'b0;
        tick(4);
        `CHK("still", 1'b1, amps_off)
        ot_in <= 1'b0;
        tick(4);
        pu_req <= 1'b1;
        @(posedge clk);
        pu_req <= 1'b0;
        tick(4);
        `CHK("cool", 1'b0, amps_off)
        $display("power done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        tick(5);
        rst_n <= 1'b1;
        t_defaults();
        t_ctrl();
        t_monitor();
        t_toggle();
        t_soft_reset();
        t_power();
        summarize();
    end
endmodule
